// File: dv/cbsm_sym_source.sv
`timescale 1ns/1ps
`default_nettype none
module cbsm_sym_source (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ready_in,
    output logic [9:0] dec_out,
    output logic [9:0] enc_out,
    output logic valid_out
);
    logic [9:0] qd[$];
    logic [9:0] qe[$];
    logic [9:0] last = 10'h155;
    task automatic push(input logic [9:0] d, input logic [9:0] e);
        qd.push_back(d);
        qe.push_back(e);
    endtask
    initial begin
        valid_out = 1'b0;
        dec_out = 10'h000;
        enc_out = 10'h3ff;
    end
    // symbol held until taken; idle lines toggle every cycle
    always @(posedge clock_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
        end else if (!valid_out || ready_in) begin
            if (valid_out) begin
                void'(qd.pop_front());
                void'(qe.pop_front());
            end
            if (qd.size() != 0) begin
                valid_out <= 1'b1;
                dec_out <= qd[0];
                enc_out <= qe[0];
            end else begin
                last = ~last;
                valid_out <= 1'b0;
                dec_out <= last;
                enc_out <= ~last;
            end
        end
    end
endmodule // cbsm_sym_source
`default_nettype wire

// File: dv/chan_bond_seq_matcher_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module chan_bond_seq_matcher_tb_top;
    logic clock_in = 1'b0, rst_in = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata_out;
    logic [9:0] dec, enc, out_sym_out;
    logic dec_en = 1'b1, sym_valid, sym_ready_out, out_valid_out;
    logic out_ready = 1'b1, hold = 1'b0, avs_waitrequest_out;
    logic bond_match_out, bond_order_out, pend = 1'b0, pv = 1'b0, ph = 1'b0;
    int fails = 0, checks = 0, nmatch = 0, cnt = 0;
    logic [31:0] rs = 32'h34a8, st = 32'h34a8;
    logic [9:0] pa[4], pb[4], hist[$], exp_sym[$];
    logic exp_m[$];
    logic [31:0] rd_val[$], rd_msk[$];
    logic b_act = 1'b0, src = 1'b1, den;
    logic [2:0] len = 3'h4;
    logic [3:0] wcfg = 4'h7, ca = 4'hf, cb = 4'hf;
    // b_act, len, src, decoder enable, wait, care b, care a
    logic [17:0] tbl[5] = '{{1'b0, 3'h4, 1'b1, 1'b1, 4'h1, 8'hff},
        {1'b1, 3'h4, 1'b1, 1'b1, 4'he, 8'h5b},
        {1'b1, 3'h2, 1'b0, 1'b1, 4'h2, 8'hfd},
        {1'b0, 3'h1, 1'b1, 1'b0, 4'h5, 8'hff},
        {1'b1, 3'h1, 1'b0, 1'b1, 4'h7, 8'h7d}};

    cbsm_top dut (.clock_in(clock_in), .rst_in(rst_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .sym_decoded_in(dec),
        .sym_encoded_in(enc), .decoder_en_in(dec_en),
        .sym_valid_in(sym_valid), .sym_ready_out(sym_ready_out),
        .out_sym_out(out_sym_out), .out_valid_out(out_valid_out),
        .out_ready_in(out_ready), .bond_match_out(bond_match_out),
        .bond_order_out(bond_order_out));
    cbsm_sym_source tx (.clock_in(clock_in), .rst_in(rst_in),
        .ready_in(sym_ready_out), .dec_out(dec), .enc_out(enc),
        .valid_out(sym_valid));

    initial begin
        forever #25 clock_in = ~clock_in;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    always @(posedge clock_in) begin
        st <= xs(st);
        out_ready <= !hold && (st[1:0] != 2'b00);
    end
    function automatic logic hit(input int i);
        logic a, b;
        a = 1'b1;
        b = b_act;
        for (int k = 0; k < 4; k++) begin
            if (k < len) begin
                if (ca[k] && hist[i+k] !== pa[k]) a = 1'b0;
                if (cb[k] && hist[i+k] !== pb[k]) b = 1'b0;
            end
        end
        return a || b;
    endfunction
    task automatic send(input logic [9:0] v, input logic same);
        logic [9:0] d;
        int n;
        d = (same || (src && dec_en)) ? v : v ^ 10'h2aa;
        hist.push_back(v);
        n = hist.size();
        if (n > 4) begin
            exp_sym.push_back(hist[n-5]);
            exp_m.push_back(hit(n - 5));
            nmatch += hit(n - 5);
        end
        tx.push(d, same ? d : d ^ 10'h2aa);
    endtask
    // pattern a, pattern b, partial a, tail alike on both paths
    task automatic stream();
        logic [9:0] v;
        for (int j = 0; j < 70; j++) begin
            rs = xs(rs);
            v = rs[9:0];
            if (j < 4) v = pa[j];
            else if (j >= 24 && j < 28) v = pb[j-24];
            else if (j >= 48 && j < 50) v = pa[j-48];
            send(v, j >= 66);
        end
    endtask
    task automatic drain();
        while (exp_sym.size() != 0) begin
            @(posedge clock_in);
        end
        repeat (20) @(posedge clock_in);
    endtask
    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock_in);
        while (avs_waitrequest_out !== 1'b0) begin
            @(posedge clock_in);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        rd_val.push_back(e);
        rd_msk.push_back(m);
        acc(1'b0, a, 32'h0);
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        if (!rst_in && avs_read && avs_waitrequest_out === 1'b0) begin
            `CMP(avs_readdata_out & rd_msk[0], rd_val[0])
            void'(rd_val.pop_front());
            void'(rd_msk.pop_front());
        end
        if (!rst_in && out_valid_out && out_ready) begin
            `CMP(out_sym_out, exp_sym[0])
            `CMP(bond_match_out, exp_m[0])
            void'(exp_sym.pop_front());
            void'(exp_m.pop_front());
        end
        if (!rst_in) begin
            if (pend) cnt++;
            if (bond_order_out) begin
                `CMP(pend ? cnt : -1, int'(wcfg))
                pend = 1'b0;
            end else if (!pend && bond_match_out && out_valid_out
                         && (ph || !pv)) begin
                pend = 1'b1;
                cnt = 0;
            end
            pv = out_valid_out;
            ph = out_valid_out && out_ready;
        end
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        fails++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        rd(8'h20, 32'hff, 32'hffffffff);
        rd(8'h24, 32'h718, 32'hfff);
        acc(1'b1, 8'h40, 32'h5a5);
        rd(8'h40, 32'h0, 32'hffffffff);
        rd(8'h21, 32'h0, 32'hffffffff);
        for (int k = 0; k < 4; k++) begin
            rs = xs(rs);
            pa[k] = rs[9:0];
            pb[k] = rs[19:10];
            acc(1'b1, 8'(4 * k), {22'h3fffff, pa[k]});
            acc(1'b1, 8'(16 + 4 * k), {22'h3fffff, pb[k]});
            rd(8'(16 + 4 * k), {22'h0, pb[k]}, 32'h3ff);
        end
        for (int e = 0; e < 5; e++) begin
            {b_act, len, src, den, wcfg, cb, ca} = tbl[e];
            dec_en <= den;
            acc(1'b1, 8'h20, {24'h0, cb, ca});
            acc(1'b1, 8'h24, {20'h0, wcfg, 3'h0, src, len, b_act});
            stream();
            drain();
        end
        // far side stalls until the buffer refuses, then drains
        hold <= 1'b1;
        stream();
        for (int n = 0; n < 300 && sym_ready_out !== 1'b0; n++) begin
            @(posedge clock_in);
        end
        `CMP(sym_ready_out, 1'b0)
        hold <= 1'b0;
        drain();
        acc(1'b1, 8'h24, 32'hf16);
        rd(8'h24, 32'h712, 32'hfff);
        acc(1'b1, 8'h24, 32'h004);
        rd(8'h24, 32'h704, 32'hfff);
        rd(8'h28, 32'(nmatch), 32'h1ffff);
        @(posedge clock_in);
        `CMP(rd_val.size(), 0)
        give_verdict();
    end
endmodule // chan_bond_seq_matcher_tb_top
`default_nettype wire

// File: rtl/cbsm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cbsm_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW:0] ZERO_C = '0;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    logic push, pop;

    assign push = in_valid_in && ready_q;
    assign pop = out_valid_out && out_ready_in;
    assign in_ready_out = ready_q;
    assign out_valid_out = (cnt_q != ZERO_C);
    assign out_data_out = mem[rd_q];

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        ready_d = (cnt_d < DEPTH_C);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wr_q] <= in_data_in;
        end
    end

    property p_no_overflow;
        @(posedge clock_in) disable iff (rst_in)
        cnt_q == DEPTH_C |-> !ready_q;
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("fifo accepts data while full");
endmodule // cbsm_fifo
`default_nettype wire

// File: rtl/cbsm_matcher.sv
`timescale 1ns/1ps
`default_nettype none
module cbsm_matcher (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire cbsm_pkg::cbsm_window_t window_in,
    input wire cbsm_pkg::cbsm_pattern_t pattern_in,
    input wire logic [2:0] len_in,
    output logic match_out
);
    logic [cbsm_pkg::NSUB-1:0] sub_ok;

    for (genvar k = 0; k < cbsm_pkg::NSUB; k++) begin : g_sub
        // symbols past the length or not cared about pass
        assign sub_ok[k] = (3'(k) >= len_in) || // R2 R3
            !pattern_in.care[k] || // R4
            (window_in[k] == pattern_in.sym[k]); // R1
    end

    assign match_out = &sub_ok;

    property p_len_one;
        @(posedge clock_in) disable iff (rst_in)
        len_in == cbsm_pkg::LEN_ONE |-> match_out ==
            (!pattern_in.care[0] || window_in[0] == pattern_in.sym[0]);
    endproperty
    a_len_one: assert property (p_len_one) // R3
        else $error("length one match not from first symbol");

    property p_dont_care;
        @(posedge clock_in) disable iff (rst_in)
        pattern_in.care == 4'h0 |-> match_out;
    endproperty
    a_dont_care: assert property (p_dont_care) // R4
        else $error("all don't-care pattern failed to match");

    property p_first_sym;
        @(posedge clock_in) disable iff (rst_in)
        pattern_in.care[0] && window_in[0] != pattern_in.sym[0]
            |-> !match_out;
    endproperty
    a_first_sym: assert property (p_first_sym) // R1
        else $error("match despite first symbol mismatch");
endmodule // cbsm_matcher
`default_nettype wire

// File: rtl/cbsm_pkg.sv
// Functional notes
// [R1] four 10-bit patterns per sequence, one symbol each
// [R2] match length only 1, 2 or 4
// [R3] length one compares first symbol only
// [R4] cleared care bit makes symbol always match
// [R5] pattern b active: either sequence triggers bonding
// [R6] pattern b inactive: only sequence a counts
// [R7] match timestamp is the skew reference point
// [R8] wait 1 to 14 cycles before bond order
// [R9] compare decoded or encoded stream per select; encoded stream is used whenever decoder_en_in is low
// [R10] match flag marks first symbol of sequence
package cbsm_pkg;
    localparam int SYM_W = 10;
    localparam int NSUB = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STAMP_W = 32;
    localparam int MCNT_W = 16;

    localparam logic [7:0] REG_PAT_A = 8'h00;
    localparam logic [7:0] REG_PAT_B = 8'h10;
    localparam logic [7:0] REG_CARE = 8'h20;
    localparam logic [7:0] REG_CTRL = 8'h24;
    localparam logic [7:0] REG_STAT = 8'h28;
    localparam logic [7:0] REG_STAMP = 8'h2c;

    localparam int CARE_A_LSB = 0;
    localparam int CARE_B_LSB = 4;
    localparam int CTRL_B_ACT_BIT = 0;
    localparam int CTRL_LEN_LSB = 1;
    localparam int CTRL_SRC_BIT = 4;
    localparam int CTRL_WAIT_LSB = 8;
    localparam int STAT_BUSY_BIT = 16;

    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [2:0] LEN_TWO = 3'h2;
    localparam logic [2:0] LEN_FOUR = 3'h4;
    localparam logic [3:0] WAIT_MIN = 4'h1;
    localparam logic [3:0] WAIT_MAX = 4'he;

    localparam logic [3:0] CARE_RST = 4'hf;
    localparam logic [2:0] LEN_RST = 3'h4;
    localparam logic [3:0] WAIT_RST = 4'h7;
    localparam logic [2:0] FILL_FULL = 3'h4;

    typedef logic [NSUB-1:0][SYM_W-1:0] cbsm_window_t;

    typedef struct packed {
        logic [NSUB-1:0][SYM_W-1:0] sym;
        logic [NSUB-1:0] care;
    } cbsm_pattern_t;

    typedef struct packed {
        logic b_active;
        logic [2:0] len;
        logic src_decoded;
        logic [3:0] wait_cycles;
    } cbsm_ctrl_t;
endpackage

// File: rtl/cbsm_top.sv
`timescale 1ns/1ps
`default_nettype none
module cbsm_top (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [9:0] sym_decoded_in,
    input wire logic [9:0] sym_encoded_in,
    input wire logic decoder_en_in,
    input wire logic sym_valid_in,
    output logic sym_ready_out,
    output logic [9:0] out_sym_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic bond_match_out,
    output logic bond_order_out
);
    cbsm_pkg::cbsm_pattern_t pat_a_q, pat_a_d, pat_b_q, pat_b_d;
    cbsm_pkg::cbsm_ctrl_t ctrl_q, ctrl_d;
    cbsm_pkg::cbsm_window_t win_q, win_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d, rd_mux, be_mask, merged;
    logic [2:0] fill_q, fill_d;
    logic [9:0] osym_q, osym_d, sel_sym, fifo_data;
    logic ovalid_q, ovalid_d, match_q, match_d;
    logic order_q, order_d;
    logic [3:0] wcnt_q, wcnt_d;
    logic [cbsm_pkg::MCNT_W-1:0] mcnt_q, mcnt_d;
    logic [cbsm_pkg::STAMP_W-1:0] cyc_q, cyc_d, stamp_q, stamp_d;
    logic fifo_valid, advance, full, hit_a, hit_b, seq_hit, hit_evt;
    logic acc, wr_acc;
    logic [2:0] new_len;
    logic [3:0] new_wait;

    // avalon slave, one wait cycle per access
    assign acc = (avs_read_in || avs_write_in) && wait_q;
    assign wr_acc = avs_write_in && !wait_q;

    always_comb begin
        rd_mux = 32'h0;
        if (avs_address_in[1:0] != 2'h0) begin
            rd_mux = 32'h0;
        end else if (avs_address_in[7:4] == cbsm_pkg::REG_PAT_A[7:4]) begin
            rd_mux = 32'(pat_a_q.sym[avs_address_in[3:2]]);
        end else if (avs_address_in[7:4] == cbsm_pkg::REG_PAT_B[7:4]) begin
            rd_mux = 32'(pat_b_q.sym[avs_address_in[3:2]]);
        end else if (avs_address_in == cbsm_pkg::REG_CARE) begin
            rd_mux[cbsm_pkg::CARE_A_LSB +: 4] = pat_a_q.care;
            rd_mux[cbsm_pkg::CARE_B_LSB +: 4] = pat_b_q.care;
        end else if (avs_address_in == cbsm_pkg::REG_CTRL) begin
            rd_mux[cbsm_pkg::CTRL_B_ACT_BIT] = ctrl_q.b_active;
            rd_mux[cbsm_pkg::CTRL_LEN_LSB +: 3] = ctrl_q.len;
            rd_mux[cbsm_pkg::CTRL_SRC_BIT] = ctrl_q.src_decoded;
            rd_mux[cbsm_pkg::CTRL_WAIT_LSB +: 4] = ctrl_q.wait_cycles;
        end else if (avs_address_in == cbsm_pkg::REG_STAT) begin
            rd_mux[cbsm_pkg::MCNT_W-1:0] = mcnt_q;
            rd_mux[cbsm_pkg::STAT_BUSY_BIT] = (wcnt_q != 4'h0);
        end else if (avs_address_in == cbsm_pkg::REG_STAMP) begin
            rd_mux = stamp_q;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            be_mask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
        end
        merged = (rd_mux & ~be_mask) | (avs_writedata_in & be_mask);
        new_len = merged[cbsm_pkg::CTRL_LEN_LSB +: 3];
        new_wait = merged[cbsm_pkg::CTRL_WAIT_LSB +: 4];
    end

    always_comb begin
        wait_d = !acc;
        rdata_d = acc && avs_read_in ? rd_mux : rdata_q;
        pat_a_d = pat_a_q;
        pat_b_d = pat_b_q;
        ctrl_d = ctrl_q;
        if (!wr_acc || avs_address_in[1:0] != 2'h0) begin
            pat_a_d = pat_a_q;
        end else if (avs_address_in[7:4] == cbsm_pkg::REG_PAT_A[7:4]) begin
            pat_a_d.sym[avs_address_in[3:2]] = merged[9:0]; // R1
        end else if (avs_address_in[7:4] == cbsm_pkg::REG_PAT_B[7:4]) begin
            pat_b_d.sym[avs_address_in[3:2]] = merged[9:0]; // R1
        end else if (avs_address_in == cbsm_pkg::REG_CARE) begin
            pat_a_d.care = merged[cbsm_pkg::CARE_A_LSB +: 4];
            pat_b_d.care = merged[cbsm_pkg::CARE_B_LSB +: 4];
        end else if (avs_address_in == cbsm_pkg::REG_CTRL) begin
            ctrl_d.b_active = merged[cbsm_pkg::CTRL_B_ACT_BIT];
            ctrl_d.src_decoded = merged[cbsm_pkg::CTRL_SRC_BIT];
            // illegal length or wait keeps the old value
            if (new_len == cbsm_pkg::LEN_ONE ||
                new_len == cbsm_pkg::LEN_TWO ||
                new_len == cbsm_pkg::LEN_FOUR) begin
                ctrl_d.len = new_len; // R2
            end
            if (new_wait >= cbsm_pkg::WAIT_MIN &&
                new_wait <= cbsm_pkg::WAIT_MAX) begin
                ctrl_d.wait_cycles = new_wait; // R8
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
            pat_a_q <= '{sym: '0, care: cbsm_pkg::CARE_RST};
            pat_b_q <= '{sym: '0, care: cbsm_pkg::CARE_RST};
            ctrl_q <= '{b_active: 1'b0, len: cbsm_pkg::LEN_RST,
                src_decoded: 1'b1, wait_cycles: cbsm_pkg::WAIT_RST};
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            pat_a_q <= pat_a_d;
            pat_b_q <= pat_b_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign avs_waitrequest_out = wait_q;
    assign avs_readdata_out = rdata_q;

    // source select, decoder output only when decoder runs
    assign sel_sym = (ctrl_q.src_decoded && decoder_en_in) ? // R9
        sym_decoded_in : sym_encoded_in;

    cbsm_fifo #(
        .WIDTH(cbsm_pkg::SYM_W),
        .DEPTH(cbsm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .in_data_in(sel_sym),
        .in_valid_in(sym_valid_in),
        .in_ready_out(sym_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(advance)
    );

    cbsm_matcher u_match_a (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .window_in(win_q),
        .pattern_in(pat_a_q),
        .len_in(ctrl_q.len),
        .match_out(hit_a)
    );

    cbsm_matcher u_match_b (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .window_in(win_q),
        .pattern_in(pat_b_q),
        .len_in(ctrl_q.len),
        .match_out(hit_b)
    );

    assign full = (fill_q == cbsm_pkg::FILL_FULL);
    assign advance = fifo_valid && (!ovalid_q || out_ready_in);
    assign seq_hit = hit_a || (ctrl_q.b_active && hit_b); // R5 R6
    assign hit_evt = advance && full && seq_hit;

    // window of four symbols, oldest in slot 0
    always_comb begin
        win_d = win_q;
        fill_d = fill_q;
        osym_d = osym_q;
        ovalid_d = ovalid_q;
        match_d = match_q;
        if (advance) begin
            for (int i = 0; i < cbsm_pkg::NSUB - 1; i++) begin
                win_d[i] = win_q[i+1];
            end
            win_d[cbsm_pkg::NSUB-1] = fifo_data;
            fill_d = full ? fill_q : fill_q + 3'h1;
            osym_d = win_q[0];
            ovalid_d = full;
            match_d = hit_evt; // R10
        end else if (out_ready_in) begin
            ovalid_d = 1'b0;
            match_d = 1'b0;
        end
    end

    // bond order delay and skew reference stamp
    always_comb begin
        cyc_d = cyc_q + 32'h1;
        stamp_d = hit_evt ? cyc_q : stamp_q; // R7
        mcnt_d = hit_evt ? mcnt_q + 16'h1 : mcnt_q;
        order_d = (wcnt_q == 4'h1); // R8
        if (wcnt_q != 4'h0) begin
            wcnt_d = wcnt_q - 4'h1;
        end else if (hit_evt) begin
            wcnt_d = ctrl_q.wait_cycles; // R7 R8
        end else begin
            wcnt_d = wcnt_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            win_q <= '0;
            fill_q <= 3'h0;
            osym_q <= 10'h0;
            ovalid_q <= 1'b0;
            match_q <= 1'b0;
            cyc_q <= 32'h0;
            stamp_q <= 32'h0;
            mcnt_q <= 16'h0;
            order_q <= 1'b0;
            wcnt_q <= 4'h0;
        end else begin
            win_q <= win_d;
            fill_q <= fill_d;
            osym_q <= osym_d;
            ovalid_q <= ovalid_d;
            match_q <= match_d;
            cyc_q <= cyc_d;
            stamp_q <= stamp_d;
            mcnt_q <= mcnt_d;
            order_q <= order_d;
            wcnt_q <= wcnt_d;
        end
    end

    assign out_sym_out = osym_q;
    assign out_valid_out = ovalid_q;
    assign bond_match_out = match_q;
    assign bond_order_out = order_q;

    property p_len_legal;
        @(posedge clock_in) disable iff (rst_in)
        ctrl_q.len == cbsm_pkg::LEN_ONE || ctrl_q.len == cbsm_pkg::LEN_TWO
            || ctrl_q.len == cbsm_pkg::LEN_FOUR;
    endproperty
    a_len_legal: assert property (p_len_legal) // R2
        else $error("match length outside 1, 2, 4");

    property p_wait_legal;
        @(posedge clock_in) disable iff (rst_in)
        ctrl_q.wait_cycles >= cbsm_pkg::WAIT_MIN &&
            ctrl_q.wait_cycles <= cbsm_pkg::WAIT_MAX;
    endproperty
    a_wait_legal: assert property (p_wait_legal) // R8
        else $error("bond wait outside 1 to 14");

    property p_b_inactive;
        @(posedge clock_in) disable iff (rst_in)
        advance && full && !ctrl_q.b_active |=> match_q == $past(hit_a);
    endproperty
    a_b_inactive: assert property (p_b_inactive) // R6
        else $error("pattern b affected match while inactive");

    property p_either;
        @(posedge clock_in) disable iff (rst_in)
        advance && full && ctrl_q.b_active && (hit_a || hit_b) |=> match_q;
    endproperty
    a_either: assert property (p_either) // R5
        else $error("match on either pattern not flagged");

    property p_order_delay;
        @(posedge clock_in) disable iff (rst_in)
        hit_evt && wcnt_q == 4'h0 && ctrl_q.wait_cycles == 4'h2
            |-> ##1 !order_q ##1 !order_q ##1 order_q;
    endproperty
    a_order_delay: assert property (p_order_delay) // R8
        else $error("bond order not after the wait count");

    property p_stamp;
        @(posedge clock_in) disable iff (rst_in)
        hit_evt |=> stamp_q == $past(cyc_q);
    endproperty
    a_stamp: assert property (p_stamp) // R7
        else $error("skew stamp not taken at match");

    property p_match_first;
        @(posedge clock_in) disable iff (rst_in)
        match_q && $past(advance)
            |-> ovalid_q && osym_q == $past(win_q[0]);
    endproperty
    a_match_first: assert property (p_match_first) // R10
        else $error("match flag not on first symbol");

    property p_source;
        @(posedge clock_in) disable iff (rst_in)
        sym_valid_in && sym_ready_out && !decoder_en_in
            |-> sel_sym == sym_encoded_in;
    endproperty
    a_source: assert property (p_source) // R9
        else $error("decoded data used with decoder off");

    property p_order_pulse;
        @(posedge clock_in) disable iff (rst_in)
        order_q |=> !order_q;
    endproperty
    a_order_pulse: assert property (p_order_pulse) // R8
        else $error("bond order longer than one cycle");
endmodule // cbsm_top
`default_nettype wire
